// File: hdl/bit_sync.sv
`timescale 1ns/1ps
module bit_sync #(
  parameter int STAGES = 2,
  parameter logic INIT = 1'b0
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic d,
  output logic q
);

  logic [STAGES-1:0] sh_reg;

  // Plain shift chain; the first stage feeds only the second
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sh_reg <= {STAGES{INIT}};
    end else begin
      sh_reg <= {sh_reg[STAGES-2:0], d};
    end
  end

  // Three or more stages: a change counts once the last two agree
  generate
    if (STAGES >= 3) begin : g_filt
      logic q_reg;
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          q_reg <= INIT;
        end else if (sh_reg[STAGES-1] == sh_reg[STAGES-2]) begin
          q_reg <= sh_reg[STAGES-1];
        end
      end
      assign q = q_reg;
    end else begin : g_plain
      assign q = sh_reg[STAGES-1];
    end
  endgenerate

endmodule: bit_sync

// File: hdl/i2c_host.sv
`timescale 1ns/1ps
module i2c_host #(
  parameter int QUARTER = i2c_pkg::QUARTER_CYC
) (
  input wire logic clk,
  input wire logic rst,
  i2c_link_if.host lnk,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire i2c_pkg::op_t cmd_op,
  input wire logic [7:0] cmd_data,
  input wire logic cmd_ack,
  output logic rsp_valid,
  output logic [7:0] rsp_data,
  output logic rsp_nack
);

  typedef enum logic [1:0] {H_IDLE, H_START, H_BIT, H_STOP} hstate_t;

  hstate_t state_reg;
  logic [1:0] q_reg;
  logic [7:0] div_reg;
  logic [3:0] bit_reg;
  logic [7:0] tx_reg;
  logic [7:0] rx_reg;
  logic rd_reg;
  logic ack_reg;
  logic scl_low_reg;
  logic sda_low_reg;
  logic scl_next;
  logic sda_next;
  logic sda_in;
  logic tick;
  logic bit_end;

  // ----------------------------------------------------------------
  // Pin sampling and quarter-period timing
  // ----------------------------------------------------------------
  bit_sync #(.STAGES(3), .INIT(1'b1)) u_sda_sync (
    .clk(clk),
    .rst(rst),
    .d(lnk.sda),
    .q(sda_in)
  );

  assign tick = (div_reg == 8'(QUARTER - 1));
  assign bit_end = (state_reg == H_BIT) && tick && (q_reg == i2c_pkg::Q_LAST);
  assign cmd_ready = (state_reg == H_IDLE);

  // Divider only runs while a command is in flight
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      div_reg <= 8'h00;
    end else if (state_reg == H_IDLE || tick) begin
      div_reg <= 8'h00;
    end else begin
      div_reg <= div_reg + 8'h01;
    end
  end

  // ----------------------------------------------------------------
  // Command sequencing
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg <= H_IDLE;
      q_reg <= 2'h0;
      bit_reg <= 4'h0;
      tx_reg <= 8'h00;
      rd_reg <= 1'b0;
      ack_reg <= 1'b0;
    end else if (state_reg == H_IDLE) begin
      if (cmd_valid) begin
        unique case (cmd_op)
          i2c_pkg::OP_START: state_reg <= H_START;
          i2c_pkg::OP_STOP: state_reg <= H_STOP;
          i2c_pkg::OP_WRITE,
          i2c_pkg::OP_READ: state_reg <= H_BIT;
        endcase
        q_reg <= 2'h0;
        bit_reg <= 4'h0;
        tx_reg <= cmd_data;
        rd_reg <= (cmd_op == i2c_pkg::OP_READ);
        ack_reg <= cmd_ack;
      end
    end else if (tick) begin
      q_reg <= q_reg + 2'h1;
      if (q_reg == i2c_pkg::Q_LAST) begin
        if (state_reg == H_BIT && bit_reg != i2c_pkg::BIT_ACK) begin
          bit_reg <= bit_reg + 4'h1;
          tx_reg <= {tx_reg[6:0], 1'b0};
        end else begin
          state_reg <= H_IDLE;
        end
      end
    end
  end

  // Sample at the end of the high half, long after the target's change
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rx_reg <= 8'h00;
      rsp_data <= 8'h00;
      rsp_nack <= 1'b0;
      rsp_valid <= 1'b0;
    end else begin
      rsp_valid <= bit_end && (bit_reg == i2c_pkg::BIT_ACK);
      if (bit_end) begin
        if (bit_reg == i2c_pkg::BIT_ACK) begin
          rsp_nack <= sda_in;
          rsp_data <= rx_reg;
        end else begin
          rx_reg <= {rx_reg[6:0], sda_in};
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Line drive: SCL low in quarters 0-1, SDA only moves from quarter 1
  // ----------------------------------------------------------------
  // Moving SDA a quarter after SCL falls keeps a false START/STOP away
  always_comb begin
    scl_next = scl_low_reg;
    sda_next = sda_low_reg;
    unique case (state_reg)
      H_IDLE: begin
        scl_next = scl_low_reg;
      end
      H_START: begin
        scl_next = ~q_reg[1];
        if (q_reg != 2'h0) begin
          sda_next = (q_reg == i2c_pkg::Q_LAST);
        end
      end
      H_STOP: begin
        scl_next = ~q_reg[1];
        if (q_reg != 2'h0) begin
          sda_next = (q_reg != i2c_pkg::Q_LAST);
        end
      end
      H_BIT: begin
        scl_next = ~q_reg[1];
        if (q_reg != 2'h0) begin
          if (bit_reg == i2c_pkg::BIT_ACK) begin
            sda_next = rd_reg && ack_reg;
          end else begin
            sda_next = ~rd_reg && ~tx_reg[7];
          end
        end
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      scl_low_reg <= 1'b0;
      sda_low_reg <= 1'b0;
    end else begin
      scl_low_reg <= scl_next;
      sda_low_reg <= sda_next;
    end
  end

  assign lnk.scl_o = 1'b0;
  assign lnk.scl_oe = scl_low_reg;
  assign lnk.h_sda_o = 1'b0;
  assign lnk.h_sda_oe = sda_low_reg;

endmodule: i2c_host

// File: hdl/i2c_target.sv
`timescale 1ns/1ps
module i2c_target #(
  parameter int PORT_ID = 0,
  parameter int OTP_N = 4
) (
  input wire logic clk,
  input wire logic rst,
  i2c_link_if.dev lnk,
  input wire logic otp_valid,
  input wire logic [6:0] otp_addr,
  input wire logic [OTP_N-1:0][7:0] otp_image,
  input wire logic rap_valid,
  output logic rap_ready,
  input wire logic rap_write,
  input wire logic [7:0] rap_offset,
  input wire logic [7:0] rap_wdata,
  output logic rap_resp_valid,
  output logic rap_refused,
  output logic [7:0] rap_rdata,
  output logic [i2c_pkg::DRV_W-1:0] drive_strength
);

  typedef enum logic [2:0] {PH_ADDR, PH_OFS, PH_WDATA, PH_RDATA, PH_IGNORE} phase_t;

  // System clock domain
  logic [7:0] bank_reg [i2c_pkg::BANK_DEPTH];
  logic [6:0] tgt_addr_reg;
  logic load_pend_reg;
  logic scl_f;
  logic sda_f;
  logic sda_d1_reg;
  logic sda_d2_reg;
  logic frame_clr_reg;
  logic ptr_tog_s;
  logic ptr_seen_reg;
  logic [7:0] ptr_cap_reg;
  logic [7:0] rd_data_reg;
  logic wr_tog_s;
  logic wr_seen_reg;
  logic wr_go;
  logic rap_in_win;
  logic rap_take;

  // Link clock domain
  logic link_rst;
  phase_t phase_reg;
  logic [3:0] bit_cnt_reg;
  logic [7:0] shift_reg;
  logic [7:0] ptr_reg;
  logic ptr_tog_reg;
  logic wr_tog_reg;
  logic [7:0] wr_addr_reg;
  logic [7:0] wr_data_reg;
  logic [7:0] tx_reg;
  logic sda_drv_reg;
  logic addr_hit;
  logic ack_now;

  // ----------------------------------------------------------------
  // START / STOP detection on the system clock
  // ----------------------------------------------------------------
  bit_sync #(.STAGES(3), .INIT(1'b1)) u_scl_sync (
    .clk(clk),
    .rst(rst),
    .d(lnk.scl),
    .q(scl_f)
  );

  bit_sync #(.STAGES(3), .INIT(1'b1)) u_sda_sync (
    .clk(clk),
    .rst(rst),
    .d(lnk.sda),
    .q(sda_f)
  );

  // SDA is judged one cycle late, so an SDA move right at an SCL fall
  // is seen with SCL already low and never counts as START or STOP
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sda_d1_reg <= 1'b1;
      sda_d2_reg <= 1'b1;
      frame_clr_reg <= 1'b0;
    end else begin
      sda_d1_reg <= sda_f;
      sda_d2_reg <= sda_d1_reg;
      frame_clr_reg <= scl_f && (sda_d1_reg != sda_d2_reg);
    end
  end

  // Link clock stops outside frames, so frame edges reset its framing and drive logic;
  // the pulse releases while SCL is still high, far from any edge
  assign link_rst = rst | frame_clr_reg;

  // ----------------------------------------------------------------
  // Byte framing on the link clock
  // ----------------------------------------------------------------
  assign addr_hit = (shift_reg[7:1] == tgt_addr_reg);
  assign ack_now = ((phase_reg == PH_ADDR) && addr_hit)
                   || (phase_reg == PH_OFS)
                   || (phase_reg == PH_WDATA);

  always_ff @(posedge lnk.scl or posedge link_rst) begin
    if (link_rst) begin
      bit_cnt_reg <= 4'h0;
      shift_reg <= 8'h00;
      phase_reg <= PH_ADDR;
    end else begin
      if (bit_cnt_reg == i2c_pkg::BIT_ACK) begin
        bit_cnt_reg <= 4'h0;
      end else begin
        bit_cnt_reg <= bit_cnt_reg + 4'h1;
        shift_reg <= {shift_reg[6:0], lnk.sda};
      end
      if (bit_cnt_reg == i2c_pkg::BIT_ACK) begin
        unique case (phase_reg)
          PH_ADDR: begin
            if (!addr_hit) begin
              phase_reg <= PH_IGNORE;
            end else if (shift_reg[0]) begin
              phase_reg <= PH_RDATA;
            end else begin
              phase_reg <= PH_OFS;
            end
          end
          PH_OFS: phase_reg <= PH_WDATA;
          PH_WDATA: phase_reg <= PH_WDATA;
          PH_RDATA: begin
            if (lnk.sda) begin
              phase_reg <= PH_IGNORE;
            end
          end
          PH_IGNORE: phase_reg <= PH_IGNORE;
        endcase
      end
    end
  end

  // Pointer survives START and STOP; only the chip reset clears it
  always_ff @(posedge lnk.scl or posedge rst) begin
    if (rst) begin
      ptr_reg <= i2c_pkg::PTR_RST;
      ptr_tog_reg <= 1'b0;
      wr_tog_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
      wr_data_reg <= 8'h00;
    end else if (bit_cnt_reg == i2c_pkg::BIT_ACK) begin
      if (phase_reg == PH_OFS) begin
        ptr_reg <= shift_reg;
        ptr_tog_reg <= ~ptr_tog_reg;
      end else if (phase_reg == PH_WDATA) begin
        wr_addr_reg <= ptr_reg;
        wr_data_reg <= shift_reg;
        wr_tog_reg <= ~wr_tog_reg;
        ptr_reg <= ptr_reg + i2c_pkg::PTR_STEP;
        ptr_tog_reg <= ~ptr_tog_reg;
      end else if (phase_reg == PH_RDATA) begin
        ptr_reg <= ptr_reg + i2c_pkg::PTR_STEP;
        ptr_tog_reg <= ~ptr_tog_reg;
      end
    end
  end

  // Drive on the falling edge so data is settled before SCL rises
  always_ff @(negedge lnk.scl or posedge link_rst) begin
    if (link_rst) begin
      tx_reg <= 8'h00;
      sda_drv_reg <= 1'b0;
    end else if (bit_cnt_reg == i2c_pkg::BIT_ACK) begin
      sda_drv_reg <= ack_now;
    end else if (phase_reg == PH_RDATA) begin
      if (bit_cnt_reg == 4'h0) begin
        tx_reg <= rd_data_reg;
        sda_drv_reg <= ~rd_data_reg[7];
      end else begin
        tx_reg <= {tx_reg[6:0], 1'b0};
        sda_drv_reg <= ~tx_reg[6];
      end
    end else begin
      sda_drv_reg <= 1'b0;
    end
  end

  assign lnk.d_sda_o = 1'b0;
  assign lnk.d_sda_oe = sda_drv_reg;

  // ----------------------------------------------------------------
  // Crossings from the link domain
  // ----------------------------------------------------------------
  bit_sync #(.STAGES(3), .INIT(1'b0)) u_ptr_sync (
    .clk(clk),
    .rst(rst),
    .d(ptr_tog_reg),
    .q(ptr_tog_s)
  );

  bit_sync #(.STAGES(3), .INIT(1'b0)) u_wr_sync (
    .clk(clk),
    .rst(rst),
    .d(wr_tog_reg),
    .q(wr_tog_s)
  );

  assign wr_go = wr_tog_s ^ wr_seen_reg;

  // Read data is prefetched at the pointer; it must settle within half
  // an SCL period, which the clock ratio gives with wide margin
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ptr_seen_reg <= 1'b0;
      wr_seen_reg <= 1'b0;
      ptr_cap_reg <= i2c_pkg::PTR_RST;
      rd_data_reg <= i2c_pkg::BANK_RST;
    end else begin
      ptr_seen_reg <= ptr_tog_s;
      wr_seen_reg <= wr_tog_s;
      if (ptr_tog_s != ptr_seen_reg) begin
        ptr_cap_reg <= ptr_reg;
      end
      rd_data_reg <= bank_reg[ptr_cap_reg];
    end
  end

  // ----------------------------------------------------------------
  // Factory values and target address
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      load_pend_reg <= 1'b1;
      tgt_addr_reg <= i2c_pkg::TGT_ADDR_DEF;
    end else begin
      load_pend_reg <= 1'b0;
      if (load_pend_reg && otp_valid) begin
        tgt_addr_reg <= otp_addr;
      end
    end
  end

  // ----------------------------------------------------------------
  // Register bank and protocol port
  // ----------------------------------------------------------------
  // Only this port's half of the low map; the top half is chip level
  assign rap_in_win = !rap_offset[i2c_pkg::RAP_TOP_BIT]
                      && (rap_offset[i2c_pkg::RAP_PORT_BIT] == PORT_ID[0]);
  // Link writes win; a protocol access waits rather than being dropped
  assign rap_ready = !rap_in_win || !(wr_go || load_pend_reg);
  assign rap_take = rap_valid && rap_ready && rap_in_win;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < i2c_pkg::BANK_DEPTH; i++) begin
        bank_reg[i] <= i2c_pkg::BANK_RST;
      end
      bank_reg[i2c_pkg::DRV_OFS] <= i2c_pkg::DRV_RST;
    end else if (load_pend_reg) begin
      if (otp_valid) begin
        for (int k = 0; k < OTP_N; k++) begin
          bank_reg[8'(int'(i2c_pkg::OTP_BASE) + k)] <= otp_image[k];
        end
      end
    end else if (wr_go) begin
      bank_reg[wr_addr_reg] <= wr_data_reg;
    end else if (rap_take && rap_write) begin
      bank_reg[rap_offset] <= rap_wdata;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rap_resp_valid <= 1'b0;
      rap_refused <= 1'b0;
      rap_rdata <= 8'h00;
    end else begin
      rap_resp_valid <= rap_valid && rap_ready;
      rap_refused <= rap_valid && !rap_in_win;
      if (rap_take && !rap_write) begin
        rap_rdata <= bank_reg[rap_offset];
      end
    end
  end

  assign drive_strength = bank_reg[i2c_pkg::DRV_OFS][i2c_pkg::DRV_W-1:0];

endmodule: i2c_target

// File: shared/i2c_link_if.sv
`timescale 1ns/1ps
interface i2c_link_if;

  logic scl_o;
  logic scl_oe;
  logic h_sda_o;
  logic h_sda_oe;
  logic d_sda_o;
  logic d_sda_oe;
  logic scl;
  logic sda;

  // ----------------------------------------------------------------
  // Open-drain wires with pull-ups: any driver pulling low wins
  // ----------------------------------------------------------------
  assign scl = scl_oe ? scl_o : 1'b1;
  assign sda = (h_sda_oe ? h_sda_o : 1'b1) & (d_sda_oe ? d_sda_o : 1'b1);

  modport host (
    output scl_o,
    output scl_oe,
    output h_sda_o,
    output h_sda_oe,
    input sda
  );

  modport dev (
    input scl,
    input sda,
    output d_sda_o,
    output d_sda_oe
  );

endinterface: i2c_link_if

// File: shared/i2c_pkg.sv
package i2c_pkg;

  // ----------------------------------------------------------------
  // Target addressing and register pointer
  // ----------------------------------------------------------------
  // Default 7-bit address: address byte 0x9e for writes, 0x9f for reads
  localparam logic [6:0] TGT_ADDR_DEF = 7'h4f;
  localparam logic [7:0] PTR_RST = 8'h00;
  localparam logic [7:0] PTR_STEP = 8'h01;
  // Bit index of the acknowledge slot within a nine-bit byte frame
  localparam logic [3:0] BIT_ACK = 4'h8;

  // ----------------------------------------------------------------
  // Register bank layout
  // ----------------------------------------------------------------
  localparam int BANK_DEPTH = 256;
  localparam logic [7:0] BANK_RST = 8'h00;
  localparam logic [7:0] OTP_BASE = 8'h30;
  localparam logic [7:0] DRV_OFS = 8'hc0;
  localparam logic [7:0] DRV_RST = 8'h01;
  localparam int DRV_W = 2;
  // Offset bits that decide what register access protocol may reach
  localparam int RAP_TOP_BIT = 7;
  localparam int RAP_PORT_BIT = 6;

  // ----------------------------------------------------------------
  // Host timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 5;
  localparam int SCL_PERIOD_NS = 160;
  localparam int QUARTER_CYC = SCL_PERIOD_NS / (4 * CLK_PERIOD_NS);
  localparam logic [1:0] Q_LAST = 2'h3;

  // Host byte-level commands
  typedef enum logic [1:0] {OP_START, OP_STOP, OP_WRITE, OP_READ} op_t;

endpackage: i2c_pkg

// File: verification/i2c_link_properties.sv
`timescale 1ns/1ps
module i2c_link_properties (
  input wire logic clk,
  input wire logic rst,
  input wire logic scl_o,
  input wire logic scl_oe,
  input wire logic h_sda_o,
  input wire logic h_sda_oe,
  input wire logic d_sda_o,
  input wire logic d_sda_oe,
  input wire logic scl,
  input wire logic sda,
  input wire logic otp_valid,
  input wire logic [6:0] otp_addr
);
  logic scl_reg;
  logic sda_reg;
  logic rd_reg;
  logic hit_reg;
  logic ign_reg;
  logic nack_reg;
  logic [3:0] bit_reg;
  logic [7:0] byte_reg;
  logic [7:0] shift_reg;
  logic [6:0] own_addr;
  logic rise;
  logic start_ev;
  logic stop_ev;
  logic slot;

  // Straps only change under reset, so a plain mux is enough
  assign own_addr = otp_valid ? otp_addr : i2c_pkg::TGT_ADDR_DEF;
  assign rise = scl & ~scl_reg;
  assign start_ev = scl & scl_reg & sda_reg & ~sda;
  assign stop_ev = scl & scl_reg & ~sda_reg & sda;
  assign slot = rise & (bit_reg == i2c_pkg::BIT_ACK);

  // Previous wire levels, idle high like the pull-ups
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      scl_reg <= 1'b1;
      sda_reg <= 1'b1;
    end else begin
      scl_reg <= scl;
      sda_reg <= sda;
    end
  end

  // Bit and byte framing; an Sr rise is counted but then reset, a P rise stays counted until the next START
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bit_reg <= 4'h0;
      byte_reg <= 8'h00;
      shift_reg <= 8'h00;
    end else if (start_ev) begin
      bit_reg <= 4'h0;
      byte_reg <= 8'h00;
    end else if (slot) begin
      bit_reg <= 4'h0;
      byte_reg <= byte_reg + 8'h01;
    end else if (rise) begin
      bit_reg <= bit_reg + 4'h1;
      shift_reg <= {shift_reg[6:0], sda};
    end
  end

  // Address decode and the states in which the target must stay off the wire
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hit_reg <= 1'b0;
      rd_reg <= 1'b0;
      ign_reg <= 1'b0;
      nack_reg <= 1'b0;
    end else if (start_ev || stop_ev) begin
      ign_reg <= 1'b0;
      nack_reg <= 1'b0;
    end else if (slot && byte_reg == 8'h00) begin
      hit_reg <= (shift_reg[7:1] == own_addr);
      rd_reg <= shift_reg[0];
      ign_reg <= (shift_reg[7:1] != own_addr);
    end else if (slot && hit_reg && rd_reg && sda) begin
      nack_reg <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Wire-level properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  sequence s_addr_slot;
    slot && byte_reg == 8'h00;
  endsequence

  sequence s_data_slot;
    slot && byte_reg != 8'h00 && hit_reg;
  endsequence

  chk_addr_ack: assert property (s_addr_slot ##0 (shift_reg[7:1] == own_addr) |-> !sda)
    else $error("own address not acknowledged");
  chk_ack_hold: assert property (s_addr_slot ##0 (shift_reg[7:1] == own_addr) |-> d_sda_oe [*4])
    else $error("address acknowledge dropped while clock high");
  chk_addr_nack: assert property (s_addr_slot ##0 (shift_reg[7:1] != own_addr) |-> sda)
    else $error("foreign address acknowledged");
  chk_miss_idle: assert property (ign_reg |-> !d_sda_oe)
    else $error("target drives after foreign address");
  chk_write_ack: assert property (s_data_slot ##0 !rd_reg |-> !sda && d_sda_oe)
    else $error("written byte not acknowledged");
  chk_read_free: assert property (s_data_slot ##0 rd_reg |-> !d_sda_oe)
    else $error("target holds data line in host ack slot");
  chk_nack_free: assert property (nack_reg |-> !d_sda_oe)
    else $error("target drives after host not-acknowledge");
  chk_sda_hold: assert property (scl && $past(scl) |-> $stable(d_sda_oe))
    else $error("target data changed while clock high");
  chk_host_hold: assert property (scl && $past(scl) && !start_ev && !stop_ev |-> $stable(h_sda_oe))
    else $error("host data changed while clock high");

endmodule: i2c_link_properties

// File: verification/test_i2c_target_register_access.sv
`timescale 1ns/1ps
module test_i2c_target_register_access;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic cmd_valid = 1'b0;
  logic cmd_ready;
  i2c_pkg::op_t cmd_op = i2c_pkg::OP_START;
  logic [7:0] cmd_data = 8'h00;
  logic cmd_ack = 1'b0;
  logic rsp_valid;
  logic [7:0] rsp_data;
  logic rsp_nack;
  logic otp_valid = 1'b0;
  logic [6:0] otp_addr = 7'h00;
  logic [3:0][7:0] otp_image = 32'h0000_0000;
  logic rap_valid = 1'b0;
  logic rap_ready;
  logic rap_write = 1'b0;
  logic [7:0] rap_offset = 8'h00;
  logic [7:0] rap_wdata = 8'h00;
  logic rap_resp_valid;
  logic rap_refused;
  logic [7:0] rap_rdata;
  logic [i2c_pkg::DRV_W-1:0] drive_strength;
  logic [7:0] mem [0:255];
  logic [7:0] ptr;
  logic [6:0] addr_now;
  // Only offsets that the register map lists are written at random
  logic [7:0] listed [0:9] = '{8'h00, 8'h10, 8'h20, 8'h30, 8'h31, 8'h32, 8'h33, 8'h37, 8'h38,
    8'h39};
  int err_total = 0;
  int samples_checked = 0;

  // Half-period toggle gives 200 MHz
  always #2.5 clk = ~clk;

  i2c_link_if lnk ();

  i2c_host u_i2c_host (.clk(clk), .rst(rst), .lnk(lnk), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_data(cmd_data), .cmd_ack(cmd_ack),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_nack(rsp_nack));

  i2c_target #(.PORT_ID(0), .OTP_N(4)) u_i2c_target (.clk(clk), .rst(rst), .lnk(lnk),
    .otp_valid(otp_valid), .otp_addr(otp_addr), .otp_image(otp_image), .rap_valid(rap_valid),
    .rap_ready(rap_ready), .rap_write(rap_write), .rap_offset(rap_offset),
    .rap_wdata(rap_wdata), .rap_resp_valid(rap_resp_valid), .rap_refused(rap_refused),
    .rap_rdata(rap_rdata), .drive_strength(drive_strength));

  i2c_link_properties u_i2c_link_properties (.clk(clk), .rst(rst), .scl_o(lnk.scl_o),
    .scl_oe(lnk.scl_oe), .h_sda_o(lnk.h_sda_o), .h_sda_oe(lnk.h_sda_oe),
    .d_sda_o(lnk.d_sda_o), .d_sda_oe(lnk.d_sda_oe), .scl(lnk.scl), .sda(lnk.sda),
    .otp_valid(otp_valid), .otp_addr(otp_addr));

  // ----------------------------------------------------------------
  // Compare, verdict and bus tasks
  // ----------------------------------------------------------------
  task automatic cmp_byte(input logic [7:0] act, input logic [7:0] exp, input string what);
    samples_checked++;
    if (act !== exp) begin
      err_total++;
      $display("[FAIL] %0t %s got %h want %h", $time, what, act, exp);
    end
  endtask: cmp_byte

  task automatic cmp_bit(input logic act, input logic exp, input string what);
    samples_checked++;
    if (act !== exp) begin
      err_total++;
      $display("[FAIL] %0t %s got %b want %b", $time, what, act, exp);
    end
  endtask: cmp_bit

  task automatic finish_test();
    if (err_total == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask: finish_test

  // One host command; byte commands wait for the response pulse
  task automatic host_cmd(input i2c_pkg::op_t op, input logic [7:0] d, input logic ack);
    int n;
    @(posedge clk);
    #1;
    cmd_valid = 1'b1;
    cmd_op = op;
    cmd_data = d;
    cmd_ack = ack;
    while (cmd_ready !== 1'b1) begin
      @(posedge clk);
      #1;
    end
    @(posedge clk);
    #1;
    cmd_valid = 1'b0;
    n = 0;
    while (op inside {i2c_pkg::OP_WRITE, i2c_pkg::OP_READ} && rsp_valid !== 1'b1 && n < 2000)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    cmp_bit(n < 2000, 1'b1, "host response");
  endtask: host_cmd

  // Start, address and offset; the model pointer follows the offset
  task automatic send_ofs(input logic [7:0] ofs);
    host_cmd(i2c_pkg::OP_START, 8'h00, 1'b0);
    host_cmd(i2c_pkg::OP_WRITE, {addr_now, 1'b0}, 1'b0);
    cmp_bit(rsp_nack, 1'b0, "write address ack");
    host_cmd(i2c_pkg::OP_WRITE, ofs, 1'b0);
    cmp_bit(rsp_nack, 1'b0, "offset ack");
    ptr = ofs;
  endtask: send_ofs

  // Write n random bytes; n of zero is an offset-only write
  task automatic i2c_write(input logic [7:0] ofs, input int n);
    logic [7:0] d;
    send_ofs(ofs);
    for (int i = 0; i < n; i++) begin
      d = 8'($urandom);
      host_cmd(i2c_pkg::OP_WRITE, d, 1'b0);
      cmp_bit(rsp_nack, 1'b0, "data ack");
      mem[ptr] = d;
      ptr++;
    end
    host_cmd(i2c_pkg::OP_STOP, 8'h00, 1'b0);
  endtask: i2c_write

  // Read n bytes, last one not acknowledged; rs selects the combined form
  task automatic i2c_read(input int n, input logic rs, input logic [7:0] ofs);
    if (rs) begin
      send_ofs(ofs);
    end
    host_cmd(i2c_pkg::OP_START, 8'h00, 1'b0);
    host_cmd(i2c_pkg::OP_WRITE, {addr_now, 1'b1}, 1'b0);
    cmp_bit(rsp_nack, 1'b0, "read address ack");
    for (int i = 0; i < n; i++) begin
      host_cmd(i2c_pkg::OP_READ, 8'h00, i != n - 1);
      cmp_byte(rsp_data, mem[ptr], "read byte");
      cmp_bit(rsp_nack, i == n - 1, "host ack echo");
      ptr++;
    end
    host_cmd(i2c_pkg::OP_STOP, 8'h00, 1'b0);
  endtask: i2c_read

  // One protocol-port access and its single response
  task automatic rap_op(input logic w, input logic [7:0] ofs, input logic [7:0] wd,
    input logic exp_ref);
    int n;
    @(posedge clk);
    #1;
    rap_valid = 1'b1;
    rap_write = w;
    rap_offset = ofs;
    rap_wdata = wd;
    while (rap_ready !== 1'b1) begin
      @(posedge clk);
      #1;
    end
    @(posedge clk);
    #1;
    rap_valid = 1'b0;
    n = 0;
    while (rap_resp_valid !== 1'b1 && n < 4) begin
      @(posedge clk);
      #1;
      n++;
    end
    cmp_bit(rap_resp_valid, 1'b1, "protocol response");
    cmp_bit(rap_refused, exp_ref, "protocol refusal");
    if (!w && !exp_ref) cmp_byte(rap_rdata, mem[ofs], "protocol read");
    if (w && !exp_ref) mem[ofs] = wd;
  endtask: rap_op

  // Reset with chosen straps; the model takes the same defaults
  task automatic do_reset(input logic ov, input logic [6:0] oa);
    rst = 1'b1;
    otp_valid = ov;
    otp_addr = oa;
    for (int i = 0; i < 4; i++) otp_image[i] = 8'($urandom);
    for (int i = 0; i < 256; i++) mem[i] = i2c_pkg::BANK_RST;
    mem[i2c_pkg::DRV_OFS] = i2c_pkg::DRV_RST;
    for (int i = 0; i < 4; i++) if (ov) mem[i2c_pkg::OTP_BASE + i] = otp_image[i];
    ptr = i2c_pkg::PTR_RST;
    addr_now = ov ? oa : i2c_pkg::TGT_ADDR_DEF;
    repeat (4) @(posedge clk);
    #1;
    rst = 1'b0;
  endtask: do_reset

  // Main sequence
  initial begin
    logic [7:0] o;
    void'($urandom(32'haf18));
    do_reset(1'b0, 7'h00);
    i2c_read(2, 1'b0, 8'h00);
    cmp_byte({6'h00, drive_strength}, i2c_pkg::DRV_RST, "drive reset");
    i2c_write(8'h30, 3);
    i2c_read(3, 1'b1, 8'h30);
    i2c_read(1, 1'b0, 8'h00);
    i2c_write(8'h10, 0);
    i2c_read(2, 1'b0, 8'h00);
    for (int k = 0; k < 4; k++) begin
      o = listed[$urandom_range(9)];
      i2c_write(o, 1);
      i2c_read(1, 1'b1, o);
    end
    i2c_write(i2c_pkg::DRV_OFS, 1);
    cmp_byte({6'h00, drive_strength}, {6'h00, mem[i2c_pkg::DRV_OFS][1:0]}, "drive");
    // Foreign address: nothing acknowledged, nothing stored
    host_cmd(i2c_pkg::OP_START, 8'h00, 1'b0);
    host_cmd(i2c_pkg::OP_WRITE, {7'h22, 1'b0}, 1'b0);
    cmp_bit(rsp_nack, 1'b1, "foreign address");
    host_cmd(i2c_pkg::OP_WRITE, 8'h30, 1'b0);
    cmp_bit(rsp_nack, 1'b1, "foreign offset");
    host_cmd(i2c_pkg::OP_STOP, 8'h00, 1'b0);
    i2c_read(1, 1'b1, 8'h30);
    rap_op(1'b1, 8'h20, 8'($urandom), 1'b0);
    i2c_read(1, 1'b1, 8'h20);
    rap_op(1'b0, 8'h31, 8'h00, 1'b0);
    rap_op(1'b1, 8'h40, 8'hff, 1'b1);
    rap_op(1'b1, 8'h80, 8'hff, 1'b1);
    i2c_read(1, 1'b1, 8'h40);
    // Factory straps: the address value is arbitrary
    do_reset(1'b1, 7'h2a);
    i2c_read(4, 1'b1, i2c_pkg::OTP_BASE);
    finish_test();
  end

  // Watchdog: the tests take about 23k cycles, so 80k means a hang
  initial begin
    #400000;
    err_total++;
    $display("[FAIL] %0t watchdog expired", $time);
    finish_test();
  end

endmodule: test_i2c_target_register_access
